/* rtl/pwec_pkg.sv */
`default_nettype none
package pwec_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_NS = 15;
  localparam int START_DELAY_NS = 100;
  localparam int START_DELAY_CYC = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 24;
  localparam int SYNC_STAGES = 3;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [CNT_W-1:0] RST_CNT = 24'h00_0000;
  localparam logic [15:0] RST_LINE = 16'h0000;
  typedef enum logic [2:0] {
    PWEC_IDLE,
    PWEC_WAIT_LINE,
    PWEC_START_DLY,
    PWEC_EXPOSE,
    PWEC_RO_DELAY,
    PWEC_READOUT
  } pwec_state_t;
endpackage : pwec_pkg
`default_nettype wire

/* rtl/pwec_if.sv */
`default_nettype none
interface pwec_if;
  logic start;
  logic busy;
  logic last_line;
  logic line_valid_flag;
  logic line_fall;
  modport seq (output start, input busy, input last_line, input line_valid_flag, input line_fall);
  modport gen (input start, output busy, output last_line, output line_valid_flag, output line_fall);
endinterface : pwec_if
`default_nettype wire

/* rtl/pwec_line_gen.sv */
`default_nettype none
module pwec_line_gen
  import pwec_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // geometry
  input wire logic [15:0] lines_i,
  input wire logic [15:0] line_len_i,
  input wire logic [15:0] line_gap_i,
  // link to sequencer
  pwec_if.gen lnk
);
  import pwec_pkg::*;
  logic [15:0] line_cnt;
  logic [15:0] pix_cnt;
  logic active;
  logic in_line;
  wire end_seg = (in_line && pix_cnt >= line_len_i - 16'h0001) || (!in_line && pix_cnt >= line_gap_i);
  wire last = (line_cnt >= lines_i - 16'h0001);
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      active <= 1'b0;
      in_line <= 1'b0;
      line_cnt <= RST_LINE;
      pix_cnt <= RST_LINE;
    end
    else if (!active)
    begin
      active <= lnk.start;
      in_line <= lnk.start;
      line_cnt <= RST_LINE;
      pix_cnt <= RST_LINE;
    end
    else if (end_seg)
    begin
      pix_cnt <= RST_LINE;
      in_line <= !in_line;
      if (in_line)
      begin
        line_cnt <= line_cnt + 16'h0001;
        if (last)
          active <= 1'b0;
      end
    end
    else
      pix_cnt <= pix_cnt + 16'h0001;
  end
  // one line per valid row
  assign lnk.line_valid_flag = active && in_line;
  assign lnk.line_fall = active && in_line && end_seg;
  assign lnk.last_line = last;
  assign lnk.busy = active;
endmodule : pwec_line_gen
`default_nettype wire

/* rtl/pwec_core.sv */
`default_nettype none
module pwec_core
  import pwec_pkg::*;
#(
  parameter int CW = CNT_W
)
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // trigger sources
  input wire logic trig_pin_i,
  input wire logic sw_trig_i,
  input wire logic [CW-1:0] sw_expo_cyc_i,
  // configuration
  input wire logic [CW-1:0] ro_delay_cyc_i,
  input wire logic [15:0] lines_i,
  input wire logic [15:0] line_len_i,
  input wire logic [15:0] line_gap_i,
  // sensor side
  output logic integrate_o,
  output logic frame_valid_flag_o,
  output logic line_valid_flag_o,
  output logic busy_o
);
  import pwec_pkg::*;
  // ----------------------------------------
  // trigger synchroniser
  // ----------------------------------------
  logic [SYNC_STAGES-1:0] sync;
  logic trig_lvl;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      sync <= '0;
    else
      sync <= {sync[SYNC_STAGES-2:0], trig_pin_i};
  end
  // change only counts once stages two and three agree
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      trig_lvl <= 1'b0;
    else if (sync[1] == sync[2])
      trig_lvl <= sync[2];
  end
  logic trig_q;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      trig_q <= 1'b0;
    else
      trig_q <= trig_lvl;
  end
  wire trig_rise = trig_lvl && !trig_q;
  wire trig_fall = !trig_lvl && trig_q;
  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  pwec_if lnk ();
  pwec_line_gen u_lines (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .lines_i(lines_i),
    .line_len_i(line_len_i),
    .line_gap_i(line_gap_i),
    .lnk(lnk)
  );
  pwec_state_t state;
  pwec_state_t next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic sw_mode;
  logic next_sw_mode;
  logic frame_valid_flag;
  assign frame_valid_flag = lnk.busy;
  wire cnt_zero = (cnt == '0);
  // pending trigger: pin rise or software request
  wire any_trig = trig_rise || sw_trig_i;
  // exposure end: pin fall or software count done; pulse length per frame
  wire expo_end = sw_mode ? cnt_zero : trig_fall;
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_sw_mode = sw_mode;
    unique case (state)
      PWEC_IDLE, PWEC_READOUT:
      begin
        if (any_trig && (state == PWEC_IDLE || frame_valid_flag))
        begin
          next_sw_mode = !trig_rise;
          next_cnt = sw_expo_cyc_i;
          // overlap aligns to line timing
          next_state = frame_valid_flag ? PWEC_WAIT_LINE : PWEC_START_DLY;
          if (!frame_valid_flag)
            next_cnt = CW'(START_DELAY_CYC);
        end
        else if (state == PWEC_READOUT && !frame_valid_flag)
          next_state = PWEC_IDLE;
      end
      PWEC_WAIT_LINE:
      begin
        if (lnk.line_fall)
          next_state = PWEC_EXPOSE;
        else if (!frame_valid_flag)
          next_state = PWEC_EXPOSE;
      end
      PWEC_START_DLY:
      begin
        next_cnt = cnt - CW'(1);
        if (cnt <= CW'(1))
        begin
          next_state = PWEC_EXPOSE;
          next_cnt = sw_expo_cyc_i;
        end
      end
      PWEC_EXPOSE:
      begin
        if (sw_mode && !cnt_zero)
          next_cnt = cnt - CW'(1); // whole clock steps
        // falling edge relies on frame valid low
        if (expo_end && !frame_valid_flag)
        begin
          next_cnt = ro_delay_cyc_i;
          next_state = PWEC_RO_DELAY;
        end
      end
      PWEC_RO_DELAY:
      begin
        next_cnt = cnt - CW'(1);
        if (cnt_zero)
        begin
          next_cnt = '0;
          next_state = PWEC_READOUT;
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state <= PWEC_IDLE;
      cnt <= RST_CNT;
      sw_mode <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      sw_mode <= next_sw_mode;
    end
  end
  // kick line generator as readout starts
  assign lnk.start = (state == PWEC_RO_DELAY) && cnt_zero;
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic integ;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      integ <= 1'b0;
    else
      integ <= (next_state == PWEC_EXPOSE);
  end
  assign integrate_o = integ;
  assign frame_valid_flag_o = frame_valid_flag;
  assign line_valid_flag_o = lnk.line_valid_flag;
  assign busy_o = (state != PWEC_IDLE);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_ro_delay_load: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == PWEC_EXPOSE && next_state == PWEC_RO_DELAY) |=> cnt == $past(ro_delay_cyc_i))
    else $error("readout delay not loaded");
  a_ro_delay_end: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == PWEC_RO_DELAY && cnt_zero) |=> state == PWEC_READOUT ##1 frame_valid_flag)
    else $error("readout not started after delay");
  a_expo_rise: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == PWEC_IDLE && trig_rise) |-> ##[1:8] integ)
    else $error("no integration after trigger");
  a_expo_fall: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == PWEC_EXPOSE && !sw_mode && trig_fall && !frame_valid_flag) |=> !integ && state == PWEC_RO_DELAY)
    else $error("integration not ended on falling edge");
  a_overlap_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == PWEC_WAIT_LINE && frame_valid_flag && !lnk.line_fall) |=> !integ)
    else $error("exposure began before line fall");
  a_start_delay: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == PWEC_IDLE && trig_rise) |=> state == PWEC_START_DLY ##1 !integ)
    else $error("short start delay wrong");
  a_sw_trig: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == PWEC_IDLE && sw_trig_i && !trig_rise) |=> sw_mode && state == PWEC_START_DLY)
    else $error("software trigger ignored");
  a_sw_count: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state == PWEC_EXPOSE && sw_mode && !cnt_zero) |=> cnt == $past(cnt) - CW'(1))
    else $error("exposure count not stepping");
  a_line_valid_flag_in_frame_valid_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    line_valid_flag_o |-> frame_valid_flag_o)
    else $error("line valid outside frame");
  c_no_overlap: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    state == PWEC_START_DLY ##[1:20] state == PWEC_EXPOSE);
  c_overlap: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    state == PWEC_WAIT_LINE ##1 state == PWEC_EXPOSE);
  c_readout: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    state == PWEC_RO_DELAY ##1 state == PWEC_READOUT);
endmodule : pwec_core
`default_nettype wire

/* testbench/pwec_trig_src.sv */
`default_nettype none
module pwec_trig_src (
  // clock
  input wire logic clk_sys_i,
  // readout state
  input wire logic frame_valid_flag_i,
  // trigger pin
  output logic trig_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // trigger source, called at a falling edge
  // ----------------------------------------
  initial trig_o = 1'b0;
  task automatic pulse(input int w);
    int k;
    trig_o = 1'b1;
    repeat (w) @(negedge clk_sys_i);
    // drop only once readout is over, else exposure runs on
    for (k = 0; k < 4000 && frame_valid_flag_i !== 1'b0; k++) @(negedge clk_sys_i);
    trig_o = 1'b0;
  endtask : pulse
endmodule : pwec_trig_src
`default_nettype wire

/* testbench/test_pulse_width_exposure_control.sv */
`default_nettype none
module test_pulse_width_exposure_control;
  import pwec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // stimulus and monitor
  // ----------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic sw_trig = 1'b0;
  logic [CNT_W-1:0] sw_expo = 24'h00_0008;
  logic [CNT_W-1:0] ro_delay = 24'h00_0000;
  logic [15:0] lines = 16'h0003;
  wire logic trig_pin;
  logic integ, fv, lv, busy, integ_q, fv_q, lv_q;
  int cyc, t_ir, t_if, t_fr, t_lf, n_lines, lf_gap, k, n_fail, n_compared;
  int exp_q[$];
  initial forever #25 clk_sys_i = ~clk_sys_i;
  pwec_trig_src src (.clk_sys_i(clk_sys_i), .frame_valid_flag_i(fv), .trig_o(trig_pin));
  pwec_core DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .trig_pin_i(trig_pin), .sw_trig_i(sw_trig),
    .sw_expo_cyc_i(sw_expo), .ro_delay_cyc_i(ro_delay), .lines_i(lines), .line_len_i(16'h0004),
    .line_gap_i(16'h0002), .integrate_o(integ), .frame_valid_flag_o(fv), .line_valid_flag_o(lv), .busy_o(busy));
  always @(posedge clk_sys_i)
    cyc++;
  // sample half a cycle after the launching edge, outputs settled
  always @(negedge clk_sys_i)
  begin
    if (lv === 1'b0 && lv_q === 1'b1) t_lf = cyc;
    if (integ === 1'b1 && integ_q === 1'b0) t_ir = cyc;
    if (integ === 1'b1 && integ_q === 1'b0) lf_gap = cyc - t_lf;
    if (integ === 1'b0 && integ_q === 1'b1) t_if = cyc;
    if (fv === 1'b1 && fv_q === 1'b0) n_lines = 0;
    if (fv === 1'b1 && fv_q === 1'b0) t_fr = cyc;
    if (lv === 1'b1 && lv_q === 1'b0) n_lines++;
    integ_q = integ;
    fv_q = fv;
    lv_q = lv;
  end
  task automatic check_cyc(input string what, input int got, input int exp_v, input int tol);
    n_compared++;
    if (got > exp_v + tol || got < exp_v - tol)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp_v);
    end
  endtask : check_cyc
  task automatic check_bit(input string what, input logic got, input logic exp_v);
    n_compared++;
    if (got !== exp_v)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp_v);
    end
  endtask : check_bit
  // bounded wait, a stuck sequencer counts as a mismatch
  task automatic wait_idle;
    for (k = 0; k < 3000 && !(busy === 1'b0 && fv === 1'b0); k++) @(negedge clk_sys_i);
    check_cyc("idle wait", k, 0, 2999);
    repeat (3) @(negedge clk_sys_i);
    check_bit("busy", busy, 1'b0);
  endtask : wait_idle
  task automatic pin_frame(input int w);
    int e;
    ro_delay = CNT_W'($urandom_range(0, 15));
    e = cyc;
    exp_q.push_back(w - 2);
    src.pulse(w);
    wait_idle;
    check_cyc("start delay", t_ir - e, SYNC_STAGES + START_DELAY_CYC + 2, 0);
    check_cyc("width", t_if - t_ir, exp_q.pop_front(), 1);
    check_cyc("ro delay", t_fr - t_if, int'(ro_delay) + 1, 1);
    check_cyc("lines", n_lines, int'(lines), 0);
    $display("pin frame of %0d cycles done", w);
  endtask : pin_frame
  task automatic end_of_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    #(50 * 20000);
    n_fail++;
    end_of_test;
  end
  initial
  begin
    void'($urandom(1));
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    for (int i = 0; i < 4; i++) pin_frame($urandom_range(6, 40));
    sw_expo = CNT_W'($urandom_range(5, 30));
    exp_q.push_back(int'(sw_expo));
    sw_trig = 1'b1;
    @(negedge clk_sys_i);
    sw_trig = 1'b0;
    wait_idle;
    check_cyc("sw width", t_if - t_ir, exp_q.pop_front(), 1);
    check_cyc("sw lines", n_lines, int'(lines), 0);
    $display("software frame done");
    lines = 16'h0004;
    src.pulse(8);
    for (k = 0; k < 200 && fv !== 1'b1; k++) @(negedge clk_sys_i);
    repeat (2) @(negedge clk_sys_i);
    src.pulse(12);
    check_cyc("line align", lf_gap, 0, 0);
    check_cyc("in frame", int'(t_ir > t_fr), 1, 0);
    wait_idle;
    check_cyc("ovl lines", n_lines, int'(lines), 0);
    $display("overlap frame done");
    end_of_test;
  end
endmodule : test_pulse_width_exposure_control
`default_nettype wire
